// ---- src/ttsc_core.sv ----
// ttsc_core: timer timebase sync core with four-bank parity-protected ram
// assumes pins and the partner's sync line are asynchronous; the partner
// is a second instance of this core joined sync_o to sync_i.
// How it works
// - bit 16 of global control picks master; reset slave
// - master drives sync pulse to the partner timer
// - slave aligns loop period to master's loop signal
// - after first pulse slave runs aligned alone
// - each further pulse realigns slave prescalers again
// - four banks, each two-port: write and read
// - 96-bit words: program, control, data fields
// - 160 instruction words, program field guarded by parity
// - read decode flags opcodes past the 30 time and angle instructions
// - 25-bit virtual counters plus 7-bit pin counters
// - 32 pins, each with adjustable suppression filter
`timescale 1ns/100ps
module ttsc_core
    import ttsc_pkg::*;
#(
    parameter int PINS = TTSC_PINS,
    parameter int WORDS = TTSC_INSTR_WORDS
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // global control
    input wire logic [TTSC_GCR_W-1:0] timer_global_control_i,
    input wire logic [TTSC_HRP_W-1:0] high_res_prescale_i,
    input wire logic [TTSC_LRP_W-1:0] loop_res_prescale_i,
    input wire logic [TTSC_FILT_W-1:0] filter_limit_i,
    // timebase sync link
    input wire logic sync_i,
    output logic sync_o,
    // timer ram access
    input wire logic ram_wr_i,
    input wire logic [7:0] ram_wr_addr_i,
    input wire logic [TTSC_WORD_W-1:0] ram_wr_data_i,
    input wire logic [7:0] ram_rd_addr_i,
    output logic [TTSC_WORD_W-1:0] ram_rd_data_o,
    output logic ram_parity_err_o,
    // pins and capture
    input wire logic [PINS-1:0] pin_i,
    output logic [PINS-1:0] pin_filt_o,
    output logic [TTSC_VCNT_W+TTSC_HWCNT_W-1:0] capture_o,
    output logic [4:0] opcode_o,
    output logic opcode_bad_o,
    output logic aligned_o,
    output logic loop_tick_o
);
    localparam int BANK_DEPTH = (WORDS + TTSC_BANKS - 1) / TTSC_BANKS;
    localparam int BAW = 6;

    function automatic logic [1:0] bank_of(input logic [7:0] a);
        return a[1:0];
    endfunction

    function automatic logic [BAW-1:0] row_of(input logic [7:0] a);
        return a[BAW+1:2];
    endfunction

    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    logic sync_s1_reg, sync_s2_reg, sync_s3_reg;
    logic [PINS-1:0] pin_s1_reg, pin_s2_reg;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync_s1_reg <= 1'b0;
            sync_s2_reg <= 1'b0;
            sync_s3_reg <= 1'b0;
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
        end else begin
            sync_s1_reg <= sync_i;
            sync_s2_reg <= sync_s1_reg;
            sync_s3_reg <= sync_s2_reg;
            pin_s1_reg <= pin_i;
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // ------------------------------------------------------------
    // prescalers and sync
    // ------------------------------------------------------------
    logic is_master;
    logic sync_rise;
    logic [TTSC_HRP_W-1:0] hr_cnt_reg, hr_cnt_next;
    logic [TTSC_LRP_W-1:0] lr_cnt_reg, lr_cnt_next;
    logic aligned_reg, aligned_next;
    logic sync_out_reg, sync_out_next;
    logic loop_tick_reg, loop_tick_next;
    logic hr_tick;

    assign is_master = timer_global_control_i[TTSC_MASTER_BIT];
    assign sync_rise = sync_s2_reg & ~sync_s3_reg;
    assign hr_tick = (hr_cnt_reg >= high_res_prescale_i);

    always_comb begin
        hr_cnt_next = hr_tick ? '0 : hr_cnt_reg + 1'b1;
        lr_cnt_next = lr_cnt_reg;
        if (hr_tick) begin
            lr_cnt_next = (lr_cnt_reg >= loop_res_prescale_i) ? '0 : lr_cnt_reg + 1'b1;
        end
        loop_tick_next = hr_tick && (lr_cnt_reg >= loop_res_prescale_i);
        aligned_next = aligned_reg;
        // master tells partner each loop start; slave never drives it
        sync_out_next = is_master && loop_tick_next;
        if (!is_master && sync_rise) begin
            // reload to loop start, whatever phase we had
            hr_cnt_next = '0;
            lr_cnt_next = '0;
            loop_tick_next = 1'b1;
            aligned_next = 1'b1;
        end
        // with no pulses the free-running counters keep alignment
        if (is_master) begin
            aligned_next = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hr_cnt_reg <= '0;
            lr_cnt_reg <= '0;
            aligned_reg <= 1'b0;
            sync_out_reg <= 1'b0;
            loop_tick_reg <= 1'b0;
        end else begin
            hr_cnt_reg <= hr_cnt_next;
            lr_cnt_reg <= lr_cnt_next;
            aligned_reg <= aligned_next;
            sync_out_reg <= sync_out_next;
            loop_tick_reg <= loop_tick_next;
        end
    end

    assign sync_o = sync_out_reg;
    assign aligned_o = aligned_reg;
    assign loop_tick_o = loop_tick_reg;

    // ------------------------------------------------------------
    // timer ram: four two-port banks, parity in the top bit
    // ------------------------------------------------------------
    logic [TTSC_WORD_W:0] bank_rd [TTSC_BANKS];
    logic [1:0] rd_bank_reg;
    logic [TTSC_WORD_W:0] rd_word;

    for (genvar b = 0; b < TTSC_BANKS; b++) begin : g_bank
        ttsc_ram_bank #(
            .WIDTH(TTSC_WORD_W + 1),
            .DEPTH(BANK_DEPTH),
            .AW(BAW)
        ) u_bank (
            .clk_i(clk_i),
            .wr_en_i(ram_wr_i && (bank_of(ram_wr_addr_i) == 2'(b))
                     && (32'(ram_wr_addr_i) < WORDS)),
            .wr_addr_i(row_of(ram_wr_addr_i)),
            .wr_data_i({^ram_wr_data_i[TTSC_WORD_W-1:TTSC_PROG_LSB],
                        ram_wr_data_i}),
            .rd_addr_i(row_of(ram_rd_addr_i)),
            .rd_data_o(bank_rd[b])
        );
    end

    assign rd_word = bank_rd[rd_bank_reg];

    // ------------------------------------------------------------
    // read path, decode and pin counters
    // ------------------------------------------------------------
    logic [TTSC_WORD_W-1:0] rd_data_reg, rd_data_next;
    logic par_err_reg, par_err_next;
    logic [4:0] opc_reg, opc_next;
    logic opc_bad_reg, opc_bad_next;
    logic rd_pend_reg;
    logic [PINS-1:0] filt_reg, filt_next;
    logic [TTSC_FILT_W-1:0] filt_cnt_reg [PINS];
    logic [TTSC_FILT_W-1:0] filt_cnt_next [PINS];
    logic [TTSC_VCNT_W-1:0] vcnt_reg, vcnt_next;
    logic [TTSC_HWCNT_W-1:0] hwcnt_reg, hwcnt_next;
    logic [TTSC_VCNT_W+TTSC_HWCNT_W-1:0] cap_reg, cap_next;

    always_comb begin
        rd_data_next = rd_data_reg;
        par_err_next = par_err_reg;
        opc_next = opc_reg;
        opc_bad_next = opc_bad_reg;
        if (rd_pend_reg) begin
            rd_data_next = rd_word[TTSC_WORD_W-1:0];
            par_err_next = rd_word[TTSC_WORD_W]
                           ^ (^rd_word[TTSC_WORD_W-1:TTSC_PROG_LSB]);
            opc_next = rd_word[TTSC_WORD_W-1 -: 5];
            opc_bad_next = (32'(rd_word[TTSC_WORD_W-1 -: 5]) >= TTSC_INSTR_COUNT);
        end
        // hw counter counts hr ticks within a loop, virtual counts loops
        hwcnt_next = loop_tick_next ? '0 : (hr_tick ? hwcnt_reg + 1'b1 : hwcnt_reg);
        vcnt_next = loop_tick_next ? vcnt_reg + 1'b1 : vcnt_reg;
        cap_next = cap_reg;
        for (int p = 0; p < PINS; p++) begin
            // change accepted only after it holds past the limit
            filt_next[p] = filt_reg[p];
            filt_cnt_next[p] = '0;
            if (pin_s2_reg[p] != filt_reg[p]) begin
                filt_cnt_next[p] = filt_cnt_reg[p] + 1'b1;
                if (filt_cnt_reg[p] >= filter_limit_i) begin
                    filt_next[p] = pin_s2_reg[p];
                    filt_cnt_next[p] = '0;
                end
            end
        end
        // capture on pin 0 rising edge; valid only inside the input limits
        if (filt_next[0] && !filt_reg[0]) begin
            cap_next = {vcnt_reg, hwcnt_reg};
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_data_reg <= '0;
            par_err_reg <= 1'b0;
            opc_reg <= '0;
            opc_bad_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            rd_bank_reg <= '0;
            filt_reg <= '0;
            filt_cnt_reg <= '{default: '0};
            vcnt_reg <= '0;
            hwcnt_reg <= '0;
            cap_reg <= '0;
        end else begin
            rd_data_reg <= rd_data_next;
            par_err_reg <= par_err_next;
            opc_reg <= opc_next;
            opc_bad_reg <= opc_bad_next;
            rd_pend_reg <= 1'b1;
            rd_bank_reg <= bank_of(ram_rd_addr_i);
            filt_reg <= filt_next;
            filt_cnt_reg <= filt_cnt_next;
            vcnt_reg <= vcnt_next;
            hwcnt_reg <= hwcnt_next;
            cap_reg <= cap_next;
        end
    end

    assign ram_rd_data_o = rd_data_reg;
    assign ram_parity_err_o = par_err_reg;
    assign opcode_o = opc_reg;
    assign opcode_bad_o = opc_bad_reg;
    assign pin_filt_o = filt_reg;
    assign capture_o = cap_reg;
endmodule

// ---- src/ttsc_pkg.sv ----
// ttsc_pkg: constants shared by the timebase sync core and its timer ram
// assumes nothing beyond a systemverilog compiler
package ttsc_pkg;
    // ------------------------------------------------------------
    // global control layout
    // ------------------------------------------------------------
    localparam int TTSC_GCR_W = 32;
    localparam int TTSC_MASTER_BIT = 16;
    localparam logic [31:0] TTSC_GCR_RESET = 32'h0000_0000;
    // ------------------------------------------------------------
    // timer ram geometry
    // ------------------------------------------------------------
    localparam int TTSC_BANKS = 4;
    localparam int TTSC_FIELD_W = 32;
    localparam int TTSC_WORD_W = 3 * TTSC_FIELD_W;
    localparam int TTSC_PROG_LSB = 2 * TTSC_FIELD_W;
    localparam int TTSC_CTRL_LSB = TTSC_FIELD_W;
    localparam int TTSC_DATA_LSB = 0;
    localparam int TTSC_INSTR_WORDS = 160;
    localparam int TTSC_INSTR_COUNT = 30;
    // ------------------------------------------------------------
    // counters and pins
    // ------------------------------------------------------------
    localparam int TTSC_VCNT_W = 25;
    localparam int TTSC_HWCNT_W = 7;
    localparam int TTSC_PINS = 32;
    localparam int TTSC_FILT_W = 8;
    localparam int TTSC_HRP_W = 6;
    localparam int TTSC_LRP_W = 7;
    // ------------------------------------------------------------
    // capture limits, in ns around prescaled clock periods
    // ------------------------------------------------------------
    localparam int TTSC_CLK_PERIOD_NS = 50;
    localparam int TTSC_CAP_MARGIN_NS = 2;
    localparam int TTSC_CAP_MIN_PHASES = 2;
endpackage

// ---- src/ttsc_ram_bank.sv ----
// ttsc_ram_bank: one two-port timer ram bank, registered read data
// assumes one clock; write and read may hit different addresses in one cycle
`timescale 1ns/100ps
module ttsc_ram_bank #(
    parameter int WIDTH = 97,
    parameter int DEPTH = 40,
    parameter int AW = 6
) (
    // clock
    input wire logic clk_i,
    // write port
    input wire logic wr_en_i,
    input wire logic [AW-1:0] wr_addr_i,
    input wire logic [WIDTH-1:0] wr_data_i,
    // read port
    input wire logic [AW-1:0] rd_addr_i,
    output logic [WIDTH-1:0] rd_data_o
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk_i) begin
        if (wr_en_i && (32'(wr_addr_i) < DEPTH)) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end
endmodule

// ---- tb/tb_top.sv ----
// tb_top: self-checking bench for the timebase sync core
// assumes a peer master model feeds sync_i
`timescale 1ns/100ps
module tb_top;
    import ttsc_pkg::*;
    typedef struct packed {logic [7:0] a; logic [95:0] d;} ttsc_row_t;
    localparam int P = 8;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [31:0] gcr = 32'hfffe_ffff;
    logic kick = 1'b0;
    logic wr = 1'b0;
    logic [7:0] wa = 8'h00;
    logic [7:0] ra = 8'h00;
    logic [95:0] wd = 96'h0;
    logic [31:0] pin = 32'h0;
    logic sync_i, sync_o, par, bad, aligned, tick;
    logic [95:0] rd;
    logic [31:0] filt, cap, cap_first;
    logic [4:0] opc;
    int err_count = 0;
    int check_count = 0;
    ttsc_row_t rows [5] = '{
        '{8'h00, 96'h0800_0000_1111_1111_2222_2222},
        '{8'h01, 96'h1000_0001_3333_3333_4444_4444},
        '{8'h02, 96'he800_0000_5555_5555_6666_6666},
        '{8'h03, 96'hf000_0000_7777_7777_8888_8888},
        '{8'h9f, 96'hf800_0001_9999_9999_aaaa_aaaa}};
    always #25 clk_i = ~clk_i;
    ttsc_peer i_ttsc_peer (.clk_i(clk_i), .kick_i(kick), .sync_o(sync_i));
    ttsc_core i_ttsc_core (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .timer_global_control_i(gcr), .high_res_prescale_i(6'h01),
        .loop_res_prescale_i(7'h03), .filter_limit_i(8'h03), .sync_i(sync_i),
        .sync_o(sync_o), .ram_wr_i(wr), .ram_wr_addr_i(wa), .ram_wr_data_i(wd),
        .ram_rd_addr_i(ra), .ram_rd_data_o(rd), .ram_parity_err_o(par),
        .pin_i(pin), .pin_filt_o(filt), .capture_o(cap), .opcode_o(opc),
        .opcode_bad_o(bad), .aligned_o(aligned), .loop_tick_o(tick));
    // ----
    // helpers
    // ----
    task automatic chk(input logic [95:0] got, input logic [95:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick_n(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    task automatic ram_wr(input logic [7:0] a, input logic [95:0] d);
        wa = a;
        wd = d;
        wr = 1'b1;
        @(negedge clk_i);
        wr = 1'b0;
        // idle cycle, so a following write never drops and raises the strobe in one step
        @(negedge clk_i);
    endtask
    // data stands once valid; opcode registers with it two edges after the address, well inside five
    task automatic ram_rd(input logic [7:0] a, input logic [95:0] d);
        ra = a;
        tick_n(5);
        chk(rd, d);
        chk(96'(opc), 96'(d[95:91]));
        chk(96'(bad), 96'(d[95:91] >= 5'd30));
        chk(96'(par), 96'h0);
    endtask
    task automatic resync;
        kick = 1'b1;
        @(negedge clk_i);
        kick = 1'b0;
        tick_n(3);
        chk(96'(tick), 96'h1);
        chk(96'(aligned), 96'h1);
        tick_n(P - 1);
        chk(96'(tick), 96'h0);
        tick_n(1);
        chk(96'(tick), 96'h1);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ----
    // sequence
    // ----
    initial begin
        // no reset edge at time zero, so the registers clear on the first clock edge
        @(negedge clk_i);
        chk(96'({sync_o, aligned, tick, par}), 96'h0);
        @(negedge clk_i);
        reset_n_i = 1'b1;
        foreach (rows[i]) ram_wr(rows[i].a, rows[i].d);
        foreach (rows[i]) ram_rd(rows[i].a, rows[i].d);
        ram_wr(8'ha0, '1);
        ram_rd(8'h00, rows[0].d);
        ra = 8'h03;
        ram_wr(8'h02, 96'h0123_4567_89ab_cdef_0011_2233);
        tick_n(3);
        chk(rd, rows[3].d);
        ram_rd(8'h02, 96'h0123_4567_89ab_cdef_0011_2233);
        chk(96'({sync_o, aligned}), 96'h0);
        resync();
        tick_n(3);
        resync();
        resync();
        tick_n(10 * P);
        chk(96'({aligned, tick}), 96'h3);
        pin = 32'h8000_0002;
        tick_n(2);
        pin = 32'h0;
        tick_n(8);
        chk(96'(filt), 96'h0);
        pin = 32'h8000_0002;
        tick_n(12);
        chk(96'(filt), 96'h8000_0002);
        // pin 0 phases of 16 clocks and a 32-clock period stay inside the capture limits
        pin[0] = 1'b1;
        tick_n(16);
        cap_first = cap;
        pin[0] = 1'b0;
        tick_n(16);
        pin[0] = 1'b1;
        tick_n(16);
        // rises four loops apart: virtual count up by four, pin count the same
        chk(96'(cap - cap_first), 96'h200);
        reset_n_i = 1'b0;
        gcr = 32'h0001_0000;
        tick_n(2);
        reset_n_i = 1'b1;
        for (int i = 0; i < 4 * P && sync_o !== 1'b1; i++) tick_n(1);
        chk(96'({sync_o, aligned}), 96'h3);
        tick_n(1);
        chk(96'(sync_o), 96'h0);
        tick_n(P - 1);
        chk(96'(sync_o), 96'h1);
        tally_and_finish();
    end
    initial begin
        #(50 * 3000);
        err_count++;
        tally_and_finish();
    end
endmodule

// ---- tb/ttsc_chk.sv ----
// ttsc_chk: port checks on the timebase sync core
// assumes prescale inputs stay fixed while the core is master
`timescale 1ns/100ps
module ttsc_chk
    import ttsc_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [TTSC_GCR_W-1:0] timer_global_control_i,
    input wire logic [TTSC_HRP_W-1:0] high_res_prescale_i,
    input wire logic [TTSC_LRP_W-1:0] loop_res_prescale_i,
    input wire logic sync_i,
    input wire logic sync_o,
    input wire logic [4:0] opcode_o,
    input wire logic opcode_bad_o,
    input wire logic aligned_o,
    input wire logic loop_tick_o
);
    // ----
    // loop gap tracking
    // ----
    logic mst;
    logic seen_reg;
    logic [15:0] gap_reg;
    logic [15:0] per;
    assign mst = timer_global_control_i[TTSC_MASTER_BIT];
    assign per = 16'((high_res_prescale_i + 1) * (loop_res_prescale_i + 1));
    // first master tick has no reference, so the gap check waits for a second
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            seen_reg <= 1'b0;
            gap_reg <= 16'h0000;
        end else begin
            seen_reg <= mst && (seen_reg || loop_tick_o);
            gap_reg <= loop_tick_o ? 16'h0000 : gap_reg + 16'h0001;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    AST_SLAVE_QUIET: assert property (!mst && !$past(mst) |-> !sync_o)
        else $error("sync driven while slave");
    AST_SYNC_PULSE: assert property (sync_o |=> !sync_o)
        else $error("sync pulse longer than one cycle");
    AST_MASTER_ALIGNED: assert property (mst [*3] |-> aligned_o)
        else $error("master not aligned");
    AST_LOOP_PERIOD: assert property (mst && seen_reg && loop_tick_o
        |-> gap_reg == per - 16'h0001)
        else $error("master loop period wrong");
    AST_RESYNC_TICK: assert property (!mst && $rose(sync_i) |-> ##3 loop_tick_o)
        else $error("no reload after sync");
    AST_SLAVE_ALIGN: assert property (!mst && $rose(aligned_o) |-> loop_tick_o)
        else $error("alignment without loop start");
    AST_STAY_ALIGNED: assert property (aligned_o && !mst |=> aligned_o || mst)
        else $error("slave lost alignment");
    AST_OPC_BAD: assert property (opcode_bad_o == (opcode_o >= 5'd30))
        else $error("opcode range flag wrong");
endmodule

bind ttsc_core ttsc_chk i_ttsc_chk (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .timer_global_control_i(timer_global_control_i),
    .high_res_prescale_i(high_res_prescale_i),
    .loop_res_prescale_i(loop_res_prescale_i),
    .sync_i(sync_i),
    .sync_o(sync_o),
    .opcode_o(opcode_o),
    .opcode_bad_o(opcode_bad_o),
    .aligned_o(aligned_o),
    .loop_tick_o(loop_tick_o)
);

// ---- tb/ttsc_peer.sv ----
// ttsc_peer: master timer standing in on the far side of the sync link
// assumes the bench asks for each pulse; line idles low between pulses
`timescale 1ns/100ps
module ttsc_peer (
    // clock and request
    input wire logic clk_i,
    input wire logic kick_i,
    // sync line
    output logic sync_o
);
    initial sync_o = 1'b0;
    // one-cycle pulse right after the edge, any time asked
    always @(posedge clk_i) begin
        sync_o <= kick_i;
    end
endmodule
